// ---- design/ext_irq_pkg.sv ----
// Shared constants and types for the external interrupt and reset block.
package ext_irq_pkg;
   // -------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------
   localparam int NUM_IRQ = 4;
   localparam int ASYNC_PIN_COUNT = 16;
   localparam int WAIT_W = 3;
   localparam int FETCH_CNT_W = 2;

   // -------------------------------------------------------------------
   // Reset and boot values
   // -------------------------------------------------------------------
   localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
   localparam logic [WAIT_W-1:0] BOOT_WAIT_MP = 3'h7;
   localparam logic [WAIT_W-1:0] BOOT_WAIT_MC = 3'h0;
   localparam logic [FETCH_CNT_W-1:0] VECTOR_FETCHES = 2'h2;
   localparam logic [FETCH_CNT_W-1:0] FETCH_ONE = 2'h1;
   localparam logic [WAIT_W-1:0] WAIT_ONE = 3'h1;
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef logic [NUM_IRQ-1:0] irq_vec_t;

   typedef enum logic [1:0] {
      BOOT_ISSUE,
      BOOT_WAIT,
      BOOT_DONE
   } boot_state_e;

   typedef struct packed {
      logic primary;
      logic expansionMem;
      logic expansionIo;
   } bus_strobe_s;

   localparam bus_strobe_s STROBES_IDLE = 3'h7;

   typedef struct packed {
      irq_vec_t core;
      irq_vec_t dma;
   } irq_take_s;
endpackage : ext_irq_pkg

// ---- design/ext_interrupt_and_reset_fetch.sv ----
// External interrupt detection, acknowledge strobe and reset-time pin logic.
//
// Contract
// - Processor mode: two vector fetches, seven waits.
// - Computer mode: two vector fetches, no waits.
// - Async-reset pins float while reset asserted.
// - Bus strobes high, data and address float.
// - Reset sets both bus wait fields seven.
// - Requests are level sensitive, no edge detect.
// - Requests sampled only at phase-one sample edges.
// - Core and DMA act at fetch boundaries.
// - Same input accepted every two cycles.
// - Late request still answered, one cycle later.
// - Acknowledge falls at decode phase start.
// - Acknowledge rises at read phase start.
`timescale 1ns/1ps
module ext_interrupt_and_reset_fetch (
   input wire logic sys_clk,
   input wire logic reset,
   input wire ext_irq_pkg::irq_vec_t extIrqLines_n,
   input wire logic microprocessorMode,
   input wire logic fetchBoundary,
   input wire ext_irq_pkg::irq_take_s irqTake,
   input wire logic ackDecodeStart,
   input wire logic ackReadStart,
   input wire ext_irq_pkg::bus_strobe_s coreStrobes,
   input wire logic coreBusDrive,
   input wire logic [ext_irq_pkg::ASYNC_PIN_COUNT-1:0] corePinOe_n,
   input wire logic waitCfgWrite,
   input wire logic [ext_irq_pkg::WAIT_W-1:0] primaryWaitIn,
   input wire logic [ext_irq_pkg::WAIT_W-1:0] expansionWaitIn,
   output ext_irq_pkg::irq_vec_t irqPending,
   output ext_irq_pkg::irq_vec_t irqServiceReq,
   output logic irqAckOut_n,
   output logic vectorFetchReq,
   output logic [ext_irq_pkg::WAIT_W-1:0] fetchWaitStates,
   output logic bootDone,
   output logic [ext_irq_pkg::WAIT_W-1:0] primaryWait,
   output logic [ext_irq_pkg::WAIT_W-1:0] expansionWait,
   output ext_irq_pkg::bus_strobe_s busStrobes,
   output logic busOe_n,
   output logic [ext_irq_pkg::ASYNC_PIN_COUNT-1:0] asyncPinOe_n
);
   // -------------------------------------------------------------------
   // Request synchronisers and detection
   // -------------------------------------------------------------------
   ext_irq_pkg::irq_vec_t irqSync1_reg;
   ext_irq_pkg::irq_vec_t irqSync2_reg;
   ext_irq_pkg::irq_vec_t holdoff_reg;
   ext_irq_pkg::irq_vec_t pending_reg;
   ext_irq_pkg::irq_vec_t pending_next;
   ext_irq_pkg::irq_vec_t irqLow;
   ext_irq_pkg::irq_vec_t irqDetect;
   ext_irq_pkg::irq_vec_t irqTaken;

   // A request that misses a sample edge is simply caught at the next one,
   // so the answer slips by one cycle but is never dropped.
   always_ff @(posedge sys_clk) begin
      irqSync1_reg <= extIrqLines_n;
      irqSync2_reg <= irqSync1_reg;
   end

   assign irqLow = ~irqSync2_reg;
   // The holdoff blanks the sample right after a detection, so a pulse
   // held across two sample edges counts once.
   assign irqDetect = irqLow & ~holdoff_reg;
   assign irqTaken = irqTake.core | irqTake.dma;
   assign pending_next = (pending_reg & ~irqTaken) | irqDetect;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         holdoff_reg <= '0;
         pending_reg <= '0;
      end else begin
         holdoff_reg <= irqDetect;
         pending_reg <= pending_next;
      end
   end

   assign irqPending = pending_reg;
   assign irqServiceReq = fetchBoundary ? pending_reg : '0;

   // -------------------------------------------------------------------
   // Acknowledge strobe
   // -------------------------------------------------------------------
   logic ack_reg;
   logic ack_next;

   assign ack_next = ackDecodeStart ? 1'b0 :
                     ackReadStart ? 1'b1 : ack_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_reg <= 1'b1;
      end else begin
         ack_reg <= ack_next;
      end
   end

   assign irqAckOut_n = ack_reg;

   // -------------------------------------------------------------------
   // Reset vector fetch sequencer
   // -------------------------------------------------------------------
   logic modeSync1_reg;
   logic modeSync2_reg;
   ext_irq_pkg::boot_state_e state_reg;
   ext_irq_pkg::boot_state_e state_next;
   logic [ext_irq_pkg::FETCH_CNT_W-1:0] fetchCnt_reg;
   logic [ext_irq_pkg::FETCH_CNT_W-1:0] fetchCnt_next;
   logic [ext_irq_pkg::WAIT_W-1:0] waitCnt_reg;
   logic [ext_irq_pkg::WAIT_W-1:0] waitCnt_next;
   logic [ext_irq_pkg::WAIT_W-1:0] bootWait;
   logic fetch_reg;
   logic [ext_irq_pkg::WAIT_W-1:0] fetchWait_reg;

   always_ff @(posedge sys_clk) begin
      modeSync1_reg <= microprocessorMode;
      modeSync2_reg <= modeSync1_reg;
   end

   assign bootWait = modeSync2_reg ? ext_irq_pkg::BOOT_WAIT_MP
                                   : ext_irq_pkg::BOOT_WAIT_MC;

   always_comb begin
      state_next = state_reg;
      fetchCnt_next = fetchCnt_reg;
      waitCnt_next = waitCnt_reg;
      case (state_reg)
         ext_irq_pkg::BOOT_ISSUE: begin
            waitCnt_next = bootWait;
            fetchCnt_next = fetchCnt_reg + ext_irq_pkg::FETCH_ONE;
            state_next = ext_irq_pkg::BOOT_WAIT;
         end
         ext_irq_pkg::BOOT_WAIT: begin
            if (waitCnt_reg == ext_irq_pkg::WAIT_ZERO) begin
               if (fetchCnt_reg == ext_irq_pkg::VECTOR_FETCHES) begin
                  state_next = ext_irq_pkg::BOOT_DONE;
               end else begin
                  state_next = ext_irq_pkg::BOOT_ISSUE;
               end
            end else begin
               waitCnt_next = waitCnt_reg - ext_irq_pkg::WAIT_ONE;
            end
         end
         ext_irq_pkg::BOOT_DONE: begin
            state_next = ext_irq_pkg::BOOT_DONE;
         end
         default: begin
            state_next = ext_irq_pkg::BOOT_DONE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= ext_irq_pkg::BOOT_ISSUE;
         fetchCnt_reg <= '0;
         waitCnt_reg <= '0;
         fetch_reg <= 1'b0;
         fetchWait_reg <= '0;
      end else begin
         state_reg <= state_next;
         fetchCnt_reg <= fetchCnt_next;
         waitCnt_reg <= waitCnt_next;
         fetch_reg <= (state_reg == ext_irq_pkg::BOOT_ISSUE);
         if (state_reg == ext_irq_pkg::BOOT_ISSUE) begin
            fetchWait_reg <= bootWait;
         end
      end
   end

   assign vectorFetchReq = fetch_reg;
   assign fetchWaitStates = fetchWait_reg;
   assign bootDone = (state_reg == ext_irq_pkg::BOOT_DONE);

   // -------------------------------------------------------------------
   // Bus wait fields and pin states
   // -------------------------------------------------------------------
   logic [ext_irq_pkg::WAIT_W-1:0] primaryWait_reg;
   logic [ext_irq_pkg::WAIT_W-1:0] expansionWait_reg;
   ext_irq_pkg::bus_strobe_s strobes_reg;
   logic busOe_reg;

   // External accesses stay slow until software lowers these fields.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         primaryWait_reg <= ext_irq_pkg::WAIT_RESET;
         expansionWait_reg <= ext_irq_pkg::WAIT_RESET;
         strobes_reg <= ext_irq_pkg::STROBES_IDLE;
         busOe_reg <= 1'b1;
      end else begin
         if (waitCfgWrite) begin
            primaryWait_reg <= primaryWaitIn;
            expansionWait_reg <= expansionWaitIn;
         end
         strobes_reg <= coreStrobes;
         busOe_reg <= ~coreBusDrive;
      end
   end

   assign primaryWait = primaryWait_reg;
   assign expansionWait = expansionWait_reg;
   // The reset term is combinational so pins release in the reset cycle
   // itself, not one clock after it.
   assign busStrobes = reset ? ext_irq_pkg::STROBES_IDLE : strobes_reg;
   assign busOe_n = reset | busOe_reg;
   assign asyncPinOe_n = reset ? '1 : corePinOe_n;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   property p_level_detect;
      @(posedge sys_clk) disable iff (reset)
      (irqLow[0] && !holdoff_reg[0]) |=> pending_reg[0];
   endproperty
   a_level_detect: assert property (p_level_detect)
      else $error("Low request was not recorded as pending.");

   property p_sample_cause;
      @(posedge sys_clk) disable iff (reset)
      $rose(pending_reg[1]) |-> $past(irqLow[1]);
   endproperty
   a_sample_cause: assert property (p_sample_cause)
      else $error("Pending rose without a sampled low request.");

   property p_two_cycle_accept;
      @(posedge sys_clk) disable iff (reset)
      irqDetect[2] |=> !irqDetect[2] ##1 (irqLow[2] -> irqDetect[2]);
   endproperty
   a_two_cycle_accept: assert property (p_two_cycle_accept)
      else $error("Detection spacing is not two cycles.");

   property p_boundary_only;
      @(posedge sys_clk) disable iff (reset)
      (|irqServiceReq) |-> (fetchBoundary && irqServiceReq == pending_reg);
   endproperty
   a_boundary_only: assert property (p_boundary_only)
      else $error("Service request outside a fetch boundary.");

   property p_pending_clear;
      @(posedge sys_clk) disable iff (reset)
      (irqTaken[3] && !irqDetect[3]) |=> !pending_reg[3];
   endproperty
   a_pending_clear: assert property (p_pending_clear)
      else $error("Taken interrupt stayed pending.");

   property p_ack_fall;
      @(posedge sys_clk) disable iff (reset)
      ackDecodeStart |=> !irqAckOut_n;
   endproperty
   a_ack_fall: assert property (p_ack_fall)
      else $error("Acknowledge did not fall at decode start.");

   property p_ack_rise;
      @(posedge sys_clk) disable iff (reset)
      (ackReadStart && !ackDecodeStart) |=> irqAckOut_n;
   endproperty
   a_ack_rise: assert property (p_ack_rise)
      else $error("Acknowledge did not rise at read start.");

   property p_mp_fetch;
      @(posedge sys_clk) disable iff (reset)
      (state_reg == ext_irq_pkg::BOOT_ISSUE && modeSync2_reg)
         |=> vectorFetchReq && fetchWaitStates == 3'h7 ##1 !vectorFetchReq;
   endproperty
   a_mp_fetch: assert property (p_mp_fetch)
      else $error("Processor-mode vector fetch lacks seven waits.");

   property p_mc_fetch;
      @(posedge sys_clk) disable iff (reset)
      (state_reg == ext_irq_pkg::BOOT_ISSUE && !modeSync2_reg)
         |=> vectorFetchReq && fetchWaitStates == 3'h0;
   endproperty
   a_mc_fetch: assert property (p_mc_fetch)
      else $error("Computer-mode vector fetch has wait states.");

   property p_wait_reset;
      @(posedge sys_clk)
      reset |=> (primaryWait == 3'h7 && expansionWait == 3'h7);
   endproperty
   a_wait_reset: assert property (p_wait_reset)
      else $error("Wait fields not seven after reset.");

   property p_pins_float;
      @(posedge sys_clk)
      reset |-> (&asyncPinOe_n);
   endproperty
   a_pins_float: assert property (p_pins_float)
      else $error("Async-reset pin driven during reset.");

   property p_bus_idle;
      @(posedge sys_clk)
      reset |-> (busStrobes == 3'h7 && busOe_n);
   endproperty
   a_bus_idle: assert property (p_bus_idle)
      else $error("Bus not idle during reset.");
endmodule : ext_interrupt_and_reset_fetch

// ---- sim/irq_requester.sv ----
// Peripheral model that drives the active-low external request lines.
`timescale 1ns/1ps
module irq_requester (
   input wire logic sys_clk,
   input wire logic fire,
   input wire logic [1:0] lineSel,
   input wire logic [1:0] lowCycles,
   output ext_irq_pkg::irq_vec_t extIrqLines_n
);
   // ---------------------------------------------------------------
   // Pulse counters
   // ---------------------------------------------------------------
   logic [1:0] holdCnt [4] = '{default: 2'h0};
   logic [1:0] lenClamped;

   // Pulses are kept to one or two sample edges so one request is seen.
   assign lenClamped = (lowCycles > 2'h2) ? 2'h2 : lowCycles;

   always @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (fire && lineSel == 2'(i)) begin
            holdCnt[i] <= lenClamped;
         end else if (holdCnt[i] != 2'h0) begin
            holdCnt[i] <= holdCnt[i] - 2'h1;
         end
      end
   end

   // Lines are pulled up, so an idle line reads high.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         extIrqLines_n[i] = (holdCnt[i] == 2'h0);
      end
   end
endmodule : irq_requester

// ---- sim/test_ext_interrupt_and_reset_fetch.sv ----
// Self-checking bench for the external interrupt and reset block.
`timescale 1ns/1ps
module test_ext_interrupt_and_reset_fetch;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] line;
      logic viaDma;
      ext_irq_pkg::irq_vec_t expPend;
   } row_s;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic microprocessorMode = 1'b1;
   logic fetchBoundary = 1'b0;
   logic ackDecodeStart = 1'b0;
   logic ackReadStart = 1'b0;
   logic coreBusDrive = 1'b1;
   logic waitCfgWrite = 1'b0;
   logic fire = 1'b0;
   logic [1:0] lineSel = 2'h0;
   logic [1:0] lowCycles = 2'h1;
   ext_irq_pkg::irq_take_s irqTake = 8'h00;
   ext_irq_pkg::bus_strobe_s coreStrobes = 3'h0;
   logic [15:0] corePinOe_n = 16'h0000;
   logic [2:0] primaryWaitIn = 3'h0;
   logic [2:0] expansionWaitIn = 3'h0;
   ext_irq_pkg::irq_vec_t extIrqLines_n, irqPending, irqServiceReq;
   logic irqAckOut_n, vectorFetchReq, bootDone, busOe_n;
   logic [2:0] fetchWaitStates, primaryWait, expansionWait;
   ext_irq_pkg::bus_strobe_s busStrobes;
   logic [15:0] asyncPinOe_n;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int hits;
   row_s rows [4];

   always #5 sys_clk = ~sys_clk;

   ext_interrupt_and_reset_fetch DUT (.sys_clk(sys_clk), .reset(reset),
      .extIrqLines_n(extIrqLines_n), .microprocessorMode(microprocessorMode),
      .fetchBoundary(fetchBoundary), .irqTake(irqTake),
      .ackDecodeStart(ackDecodeStart), .ackReadStart(ackReadStart),
      .coreStrobes(coreStrobes), .coreBusDrive(coreBusDrive),
      .corePinOe_n(corePinOe_n), .waitCfgWrite(waitCfgWrite),
      .primaryWaitIn(primaryWaitIn), .expansionWaitIn(expansionWaitIn),
      .irqPending(irqPending), .irqServiceReq(irqServiceReq),
      .irqAckOut_n(irqAckOut_n), .vectorFetchReq(vectorFetchReq),
      .fetchWaitStates(fetchWaitStates), .bootDone(bootDone),
      .primaryWait(primaryWait), .expansionWait(expansionWait),
      .busStrobes(busStrobes), .busOe_n(busOe_n),
      .asyncPinOe_n(asyncPinOe_n));

   irq_requester requester (.sys_clk(sys_clk), .fire(fire),
      .lineSel(lineSel), .lowCycles(lowCycles),
      .extIrqLines_n(extIrqLines_n));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick

   task automatic pulse(input logic [1:0] sel, input logic [1:0] len);
      lineSel = sel;
      lowCycles = len;
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
   endtask : pulse

   // A late sample costs one more cycle, so the wait allows slack.
   task automatic wait_pend();
      int n;
      n = 0;
      while (irqPending === 4'h0 && n < 8) begin
         tick(1);
         n++;
      end
   endtask : wait_pend

   task automatic take(input ext_irq_pkg::irq_vec_t m, input logic dma);
      irqTake.core = dma ? 4'h0 : m;
      irqTake.dma = dma ? m : 4'h0;
      tick(1);
      irqTake = 8'h00;
   endtask : take

   task automatic count_hits();
      hits = 0;
      repeat (4) begin
         tick(1);
         if (irqPending !== 4'h0) hits++;
      end
   endtask : count_hits

   task automatic boot(input logic mp, input logic [2:0] expWait);
      int fetches;
      fetches = 0;
      reset = 1'b1;
      microprocessorMode = mp;
      tick(20);
      check("strobes", 16'(busStrobes), 16'h0007);
      check("busOe", 16'(busOe_n), 16'h0001);
      check("pinOe", asyncPinOe_n, 16'hFFFF);
      check("primWait", 16'(primaryWait), 16'h0007);
      check("expWait", 16'(expansionWait), 16'h0007);
      reset = 1'b0;
      repeat (40) begin
         tick(1);
         if (vectorFetchReq === 1'b1) begin
            fetches++;
            check("fetchWait", 16'(fetchWaitStates), 16'(expWait));
         end
      end
      check("fetches", 16'(fetches), 16'h0002);
      check("bootDone", 16'(bootDone), 16'h0001);
      check("pinOeRun", asyncPinOe_n, corePinOe_n);
      check("busOeRun", 16'(busOe_n), 16'h0000);
   endtask : boot

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rows[0] = '{2'h0, 1'b0, 4'h1};
      rows[1] = '{2'h1, 1'b1, 4'h2};
      rows[2] = '{2'h2, 1'b0, 4'h4};
      rows[3] = '{2'h3, 1'b1, 4'h8};
      boot(1'b1, 3'h7);
      foreach (rows[i]) begin
         pulse(rows[i].line, 2'h1);
         wait_pend();
         check("pend", 16'(irqPending), 16'(rows[i].expPend));
         check("svcIdle", 16'(irqServiceReq), 16'h0000);
         fetchBoundary = 1'b1;
         tick(1);
         check("svc", 16'(irqServiceReq), 16'(rows[i].expPend));
         take(rows[i].expPend, rows[i].viaDma);
         fetchBoundary = 1'b0;
         check("cleared", 16'(irqPending), 16'h0000);
      end
      // Two short pulses two cycles apart must give two requests.
      pulse(2'h2, 2'h1);
      tick(1);
      pulse(2'h2, 2'h1);
      wait_pend();
      take(4'h4, 1'b0);
      count_hits();
      check("again", 16'(hits > 0), 16'h0001);
      take(4'h4, 1'b0);
      check("againClr", 16'(irqPending), 16'h0000);
      // A two-cycle pulse is still only one request.
      pulse(2'h1, 2'h2);
      wait_pend();
      take(4'h2, 1'b0);
      count_hits();
      check("single", 16'(hits), 16'h0000);
      check("ackPre", 16'(irqAckOut_n), 16'h0001);
      ackDecodeStart = 1'b1;
      tick(1);
      ackDecodeStart = 1'b0;
      check("ackLow", 16'(irqAckOut_n), 16'h0000);
      tick(2);
      check("ackHold", 16'(irqAckOut_n), 16'h0000);
      ackReadStart = 1'b1;
      tick(1);
      ackReadStart = 1'b0;
      check("ackHigh", 16'(irqAckOut_n), 16'h0001);
      coreStrobes = 3'h5;
      primaryWaitIn = 3'h2;
      expansionWaitIn = 3'h5;
      waitCfgWrite = 1'b1;
      tick(1);
      waitCfgWrite = 1'b0;
      check("primNew", 16'(primaryWait), 16'h0002);
      check("expNew", 16'(expansionWait), 16'h0005);
      check("strobeRun", 16'(busStrobes), 16'h0005);
      boot(1'b0, 3'h0);
      stop_test();
   end

   // The whole run needs under two hundred cycles; this cuts off a hang.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles >= 2000) begin
         mismatches++;
         stop_test();
      end
   end
endmodule : test_ext_interrupt_and_reset_fetch
